// File: include/tsec_pkg.sv
// package for the transponder serial eeprom controller
// assumes a 250 mhz system clock; the array is flip-flop based
package tsec_pkg;
    // clock rate and derived timing
    localparam int CLK_MHZ = 250;
    localparam int PROG_TIME_MS = 10;
    localparam int PROG_CYCLES = PROG_TIME_MS * 1000 * CLK_MHZ;
    localparam int BFS_TIME_US = 100;
    localparam int BFS_CYCLES = BFS_TIME_US * CLK_MHZ;
    localparam int RST_TIME_US = 1;
    localparam int RST_CYCLES = RST_TIME_US * CLK_MHZ;
    localparam int PROG_W = 22;
    localparam int FLT_W = 16;
    localparam int RST_W = 9;

    // array shape
    localparam int ROWS = 32;
    localparam int ROW_W = 5;
    localparam int WORD_W = 16;

    // control byte field positions
    localparam int CB_RNW = 0;
    localparam int CB_C0 = 1;
    localparam int CB_C1 = 2;
    localparam int CB_ROW_LSB = 3;
    localparam int CB_ROW_MSB = 7;
    localparam int CB_PM_BIT = 3;
    localparam int CB_MODSEL_BIT = 4;
    localparam int CB_MODEN_BIT = 5;
    localparam logic [2:0] SPECIAL_TAIL = 3'h7;
    localparam logic [1:0] SPECIAL_HEAD = 2'h3;
    localparam logic [2:0] RESERVED_TAIL = 3'h6;

    // synchroniser lane positions
    localparam int SYNC_W = 6;
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_ON = 2;
    localparam int SY_OFF = 3;
    localparam int SY_DAMP = 4;
    localparam int SY_TOG = 5;
    // bus lanes idle high, so their filtered copies must leave reset high too
    localparam logic [SYNC_W-1:0] SYNC_RST = 6'h03;

    // reset values
    localparam logic PM_AUTO_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_MOD, ST_WAIT
    } tsec_state_e;
endpackage

// File: include/tsec_sync_if.sv
// bundle of raw asynchronous inputs and their filtered copies
// assumes the sync module and the top share sys_clk
`timescale 1ns/1ns
interface tsec_sync_if #(parameter int W = 1) ();
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// File: src/tsec_sync.sv
// three-stage input synchroniser with agreement filter per lane
// assumes raw lanes are asynchronous to clk
`timescale 1ns/1ns
module tsec_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    tsec_sync_if.sync s
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] clean_ff;

    // first stage feeds only the second; a lane changes once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // lanes start at their idle level so no false edge follows reset
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            clean_ff <= RST_VAL;
        end else if (clk_en) begin
            s1_ff <= s.raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    clean_ff[i] <= s3_ff[i];
                end
            end
        end
    end

    assign s.clean = clean_ff;
endmodule

// File: src/tsec_top.sv
// two-wire slave, row array, power manager and bit modulator of the transponder front end
// assumes the master drives scl; sda and nrst are open drain with external pull-ups
`timescale 1ns/1ns
module tsec_top
    import tsec_pkg::*;
#(
    parameter int PROG_CYC = tsec_pkg::PROG_CYCLES,
    parameter int BFS_CYC = tsec_pkg::BFS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic coil_above_on_thr,
    input wire logic coil_below_off_thr,
    input wire logic coil_damping_ctrl_in,
    output logic field_gap_detect_out,
    output logic wake_pulse,
    output logic field_supply,
    output logic pm_auto,
    output logic nrst_out,
    output logic nrst_oe,
    output logic damp_drive,
    output logic prog_busy
);
    import tsec_pkg::*;

    tsec_sync_if #(.W(SYNC_W)) sif ();

    // link domain: bit capture on scl rise for the modulator
    logic link_bit_ff;
    logic link_tog_ff;

    // system domain state
    tsec_state_e state_ff;
    logic scl_q_ff, sda_q_ff, tog_q_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] shreg_ff;
    logic got8_ff, is_ctrl_ff, ack_ff, acked_ff;
    logic rnw_ff, hi_first_ff, rd_idx_ff, mod_manch_ff;
    logic [1:0] wr_cnt_ff;
    logic [ROW_W-1:0] row_ff;
    logic [WORD_W-1:0] buf_ff;
    logic [WORD_W-1:0] mem_ff [ROWS];
    logic commit_ff, pm_req_ff, pm_val_ff;
    logic [PROG_W-1:0] prog_cnt_ff;
    logic gap_ff, supply_ff, wake_ff, pm_auto_ff;
    logic [FLT_W-1:0] flt_cnt_ff;
    logic [RST_W-1:0] rst_cnt_ff;
    logic nrst_oe_ff, sda_oe_ff, damp_ff, busy_ff;

    logic scl_c, sda_c, tog_c;
    logic scl_rise, scl_fall, start_det, stop_det, busy;
    logic [7:0] rx_byte, cur_byte;
    logic is_special, is_reserved, ack_ok, buf_hi_slot, flt_full, nxt_supply;
    logic [ROW_W-1:0] nxt_row;

    assign sif.raw = {link_tog_ff, coil_damping_ctrl_in, coil_below_off_thr,
                      coil_above_on_thr, sda_in, scl_clk};

    tsec_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .s(sif)
    );

    assign scl_c = sif.clean[SY_SCL];
    assign sda_c = sif.clean[SY_SDA];
    assign tog_c = sif.clean[SY_TOG];

    // bus conditions from filtered lines; changes with scl high are conditions
    assign scl_rise = scl_c & ~scl_q_ff;
    assign scl_fall = ~scl_c & scl_q_ff;
    assign start_det = scl_c & scl_q_ff & sda_c & ~sda_q_ff;
    assign stop_det = scl_c & scl_q_ff & ~sda_c & sda_q_ff;
    assign busy = (prog_cnt_ff != '0);

    // byte decoding helpers
    assign rx_byte = {shreg_ff[6:0], sda_c};
    assign is_special = (shreg_ff[7:6] == SPECIAL_HEAD) && (shreg_ff[2:0] == SPECIAL_TAIL);
    assign is_reserved = (shreg_ff[2:0] == RESERVED_TAIL);
    assign ack_ok = ~busy && (is_ctrl_ff ? ~is_reserved : (wr_cnt_ff != 2'h2));
    assign buf_hi_slot = hi_first_ff ^ wr_cnt_ff[0];
    assign cur_byte = (hi_first_ff ^ rd_idx_ff) ? buf_ff[15:8] : buf_ff[7:0];
    assign nxt_row = hi_first_ff ? row_ff - 5'h01 : row_ff + 5'h01;

    // link capture runs only while the master clocks scl
    always_ff @(posedge scl_clk or negedge resetn) begin
        if (!resetn) begin
            link_bit_ff <= 1'b0;
            link_tog_ff <= 1'b0;
        end else begin
            link_bit_ff <= sda_in;
            link_tog_ff <= ~link_tog_ff;
        end
    end

    // edge history of the filtered lines
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            tog_q_ff <= 1'b0;
        end else if (clk_en) begin
            scl_q_ff <= scl_c;
            sda_q_ff <= sda_c;
            tog_q_ff <= tog_c;
        end
    end

    // protocol engine; stop and start override every state
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 3'h0;
            shreg_ff <= 8'h00;
            got8_ff <= 1'b0;
            is_ctrl_ff <= 1'b0;
            ack_ff <= 1'b0;
            acked_ff <= 1'b0;
            rnw_ff <= 1'b0;
            hi_first_ff <= 1'b0;
            rd_idx_ff <= 1'b0;
            mod_manch_ff <= 1'b0;
            wr_cnt_ff <= 2'h0;
            row_ff <= '0;
            buf_ff <= '0;
            commit_ff <= 1'b0;
            pm_req_ff <= 1'b0;
            pm_val_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (clk_en) begin
            commit_ff <= 1'b0;
            pm_req_ff <= 1'b0;
            if (stop_det) begin
                state_ff <= ST_IDLE;
                sda_oe_ff <= 1'b0;
                // programming starts only after a write that carried data
                commit_ff <= ~rnw_ff && (wr_cnt_ff != 2'h0) && ~busy;
                wr_cnt_ff <= 2'h0;
            end else if (start_det) begin
                state_ff <= ST_RX;
                is_ctrl_ff <= 1'b1;
                bit_cnt_ff <= 3'h0;
                got8_ff <= 1'b0;
                wr_cnt_ff <= 2'h0;
                rnw_ff <= 1'b1;
                sda_oe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_RX: begin
                        if (scl_rise) begin
                            shreg_ff <= rx_byte;
                            bit_cnt_ff <= bit_cnt_ff + 3'h1;
                            got8_ff <= (bit_cnt_ff == 3'h7);
                        end else if (scl_fall && got8_ff) begin
                            got8_ff <= 1'b0;
                            state_ff <= ST_RX_ACK;
                            sda_oe_ff <= ack_ok;
                            ack_ff <= ack_ok;
                            if (!ack_ok) begin
                                // no acknowledge: byte discarded
                            end else if (is_ctrl_ff && is_special) begin
                                pm_req_ff <= 1'b1;
                                pm_val_ff <= shreg_ff[CB_PM_BIT];
                                mod_manch_ff <= shreg_ff[CB_MODSEL_BIT];
                                rnw_ff <= 1'b1;
                            end else if (is_ctrl_ff) begin
                                row_ff <= shreg_ff[CB_ROW_MSB:CB_ROW_LSB];
                                hi_first_ff <= shreg_ff[CB_C1];
                                rnw_ff <= shreg_ff[CB_RNW];
                                rd_idx_ff <= 1'b0;
                                buf_ff <= mem_ff[shreg_ff[CB_ROW_MSB:CB_ROW_LSB]];
                            end else begin
                                if (buf_hi_slot) begin
                                    buf_ff[15:8] <= shreg_ff;
                                end else begin
                                    buf_ff[7:0] <= shreg_ff;
                                end
                                wr_cnt_ff <= wr_cnt_ff + 2'h1;
                            end
                        end
                    end
                    ST_RX_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_ff <= 3'h0;
                            if (!ack_ff) begin
                                state_ff <= ST_WAIT;
                                sda_oe_ff <= 1'b0;
                            end else if (is_ctrl_ff && is_special
                                         && !shreg_ff[CB_MODEN_BIT]) begin
                                state_ff <= ST_MOD;
                                sda_oe_ff <= 1'b0;
                            end else if (is_ctrl_ff && is_special) begin
                                state_ff <= ST_WAIT; // power command takes no data
                                sda_oe_ff <= 1'b0;
                            end else if (is_ctrl_ff && rnw_ff) begin
                                state_ff <= ST_TX;
                                shreg_ff <= cur_byte;
                                sda_oe_ff <= ~cur_byte[7];
                            end else begin
                                state_ff <= ST_RX;
                                is_ctrl_ff <= 1'b0;
                                sda_oe_ff <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            bit_cnt_ff <= bit_cnt_ff + 3'h1;
                            shreg_ff <= {shreg_ff[6:0], 1'b0};
                            acked_ff <= 1'b0;
                            if (bit_cnt_ff == 3'h7) begin
                                state_ff <= ST_TX_ACK;
                                sda_oe_ff <= 1'b0; // release for master ack
                                rd_idx_ff <= ~rd_idx_ff;
                                if (rd_idx_ff) begin
                                    row_ff <= nxt_row;
                                    buf_ff <= mem_ff[nxt_row];
                                end
                            end else begin
                                sda_oe_ff <= ~shreg_ff[6];
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        if (scl_rise) begin
                            if (sda_c) begin
                                state_ff <= ST_WAIT;
                            end else begin
                                acked_ff <= 1'b1;
                            end
                        end else if (scl_fall && acked_ff) begin
                            state_ff <= ST_TX;
                            bit_cnt_ff <= 3'h0;
                            shreg_ff <= cur_byte;
                            sda_oe_ff <= ~cur_byte[7];
                        end
                    end
                    ST_MOD, ST_WAIT, ST_IDLE: begin
                        sda_oe_ff <= 1'b0;
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                        sda_oe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // array write-back and programming timer; bus bytes go unacknowledged while it runs
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prog_cnt_ff <= '0;
            busy_ff <= 1'b0;
            for (int i = 0; i < ROWS; i++) begin
                mem_ff[i] <= '0;
            end
        end else if (clk_en) begin
            if (commit_ff) begin
                mem_ff[row_ff] <= buf_ff;
                prog_cnt_ff <= PROG_W'(PROG_CYC);
            end else if (busy) begin
                prog_cnt_ff <= prog_cnt_ff - 1'b1;
            end
            busy_ff <= commit_ff || (prog_cnt_ff > PROG_W'(1));
        end
    end

    // gap detector as a schmitt on the two threshold comparators
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_ff <= 1'b0;
        end else if (clk_en) begin
            if (sif.clean[SY_ON]) begin
                gap_ff <= 1'b1;
            end else if (sif.clean[SY_OFF]) begin
                gap_ff <= 1'b0;
            end
        end
    end

    // low-pass on field detection: field must persist for the switch delay
    assign flt_full = (flt_cnt_ff == FLT_W'(BFS_CYC));
    assign nxt_supply = pm_auto_ff && (supply_ff ? gap_ff : flt_full);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flt_cnt_ff <= '0;
        end else if (clk_en) begin
            if (!gap_ff) begin
                flt_cnt_ff <= '0;
            end else if (!flt_full) begin
                flt_cnt_ff <= flt_cnt_ff + 1'b1;
            end
        end
    end

    // power manager: mode command, supply select, wake and field-loss reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pm_auto_ff <= PM_AUTO_RST;
            supply_ff <= 1'b0;
            wake_ff <= 1'b0;
            rst_cnt_ff <= '0;
            nrst_oe_ff <= 1'b0;
        end else if (clk_en) begin
            if (pm_req_ff) begin
                pm_auto_ff <= pm_val_ff;
            end
            supply_ff <= nxt_supply;
            wake_ff <= nxt_supply & ~supply_ff;
            if (supply_ff && !nxt_supply && !gap_ff) begin
                rst_cnt_ff <= RST_W'(RST_CYCLES);
            end else if (rst_cnt_ff != '0) begin
                rst_cnt_ff <= rst_cnt_ff - 1'b1;
            end
            nrst_oe_ff <= (rst_cnt_ff != '0);
        end
    end

    // damping drive: serial-fed encoder in modulator mode, else the pin
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            damp_ff <= 1'b0;
        end else if (clk_en) begin
            if (state_ff != ST_MOD) begin
                damp_ff <= sif.clean[SY_DAMP];
            end else if (tog_c != tog_q_ff) begin
                // new bit: manchester shows the bit, bi-phase flips at the boundary
                damp_ff <= mod_manch_ff ? link_bit_ff : ~damp_ff;
            end else if (scl_fall) begin
                // mid-bit: manchester inverts, bi-phase flips only for a zero
                damp_ff <= mod_manch_ff ? ~link_bit_ff : (damp_ff ^ ~link_bit_ff);
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign field_gap_detect_out = gap_ff;
    assign wake_pulse = wake_ff;
    assign field_supply = supply_ff;
    assign pm_auto = pm_auto_ff;
    assign nrst_out = 1'b0;
    assign nrst_oe = nrst_oe_ff;
    assign damp_drive = damp_ff;
    assign prog_busy = busy_ff;

    property p_gap_drop;
        @(posedge sys_clk) disable iff (!resetn || !clk_en)
        !sif.clean[SY_ON] && sif.clean[SY_OFF] |=> !field_gap_detect_out;
    endproperty
    a_gap_drop: assert property (p_gap_drop) else $error("gap output not low");

    property p_wake;
        @(posedge sys_clk) disable iff (!resetn || !clk_en)
        $rose(field_supply) |-> wake_pulse ##1 !wake_pulse;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse missing");

    property p_auto_off;
        @(posedge sys_clk) disable iff (!resetn || !clk_en)
        !pm_auto_ff |=> !field_supply;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("field supply with auto off");

    property p_filter;
        @(posedge sys_clk) disable iff (!resetn || !clk_en)
        $rose(field_supply) |-> $past(flt_full) && $past(gap_ff);
    endproperty
    a_filter: assert property (p_filter) else $error("supply switched before delay");

    property p_field_rst;
        @(posedge sys_clk) disable iff (!resetn || !clk_en)
        $fell(field_supply) && !gap_ff ##1 1'b1 |=> nrst_oe [*4];
    endproperty
    a_field_rst: assert property (p_field_rst) else $error("no reset on field loss");

    property p_standby;
        @(posedge sys_clk) disable iff (!resetn || !clk_en)
        stop_det |=> (state_ff == ST_IDLE) && !sda_oe;
    endproperty
    a_standby: assert property (p_standby) else $error("sda driven in standby");

    property p_nack;
        @(posedge sys_clk) disable iff (!resetn || !clk_en)
        (state_ff == ST_TX_ACK) && scl_rise && sda_c && !start_det && !stop_det
        |=> (state_ff == ST_WAIT) ##1 !sda_oe;
    endproperty
    a_nack: assert property (p_nack) else $error("kept sending after nack");

    property p_busy_quiet;
        @(posedge sys_clk) disable iff (!resetn || !clk_en)
        busy && (state_ff == ST_RX) && scl_fall && got8_ff |=> !sda_oe;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("ack while programming");

    property p_start;
        @(posedge sys_clk) disable iff (!resetn || !clk_en)
        start_det && !stop_det |=> (state_ff == ST_RX) && is_ctrl_ff && !sda_oe;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
endmodule

// File: dv/tsec_mst.sv
// two-wire bus master model with an open-drain data line
// assumes the bench calls its tasks; every change lands on a sys_clk fall
`timescale 1ns/1ns
module tsec_mst (
    input wire logic clk,
    input wire logic dev_oe,
    output logic scl,
    output logic sda
);
    logic drv_low;
    // wired-and with pull-up, so a released line reads high
    assign sda = ~(drv_low | dev_oe);
    initial begin
        scl = 1'b1;
        drv_low = 1'b0;
    end
    // phases well above the device's input sync latency
    task automatic hp();
        repeat (10) @(negedge clk);
    endtask
    // data rising with the clock high opens a transfer
    task automatic start();
        scl = 1'b0;
        hp();
        drv_low = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        drv_low = 1'b0;
        hp();
        scl = 1'b0;
        hp();
    endtask
    // data falling with the clock high closes it, then back to idle high
    task automatic stop();
        drv_low = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        drv_low = 1'b1;
        hp();
        scl = 1'b0;
        hp();
        drv_low = 1'b0;
        hp();
        scl = 1'b1;
        hp();
    endtask
    // data moves only while the clock is low
    task automatic bit1(input logic b, output logic r);
        drv_low = ~b;
        hp();
        scl = 1'b1;
        hp();
        hp();
        r = sda;
        scl = 1'b0;
        hp();
    endtask
    // eight bits then the acknowledge clock; mack low releases the line
    task automatic xb(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit1(d[i], r);
            q[i] = r;
        end
        bit1(~mack, r);
        ack = ~r;
    endtask
endmodule

// File: dv/tb.sv
// self-checking bench for the transponder serial eeprom controller
// assumes tsec_mst as bus master and shortened programming and filter counts
`timescale 1ns/1ns
module tb;
    import tsec_pkg::*;
    localparam int PC = 2000;
    localparam int BC = 20;
    logic sys_clk, resetn, clk_en, scl, sda, above, below, damp_in;
    logic sda_oe, fgd, wake, fsup, pma, nrst_oe, ddrv, busy, a, b, e;
    logic [7:0] q;
    logic [4:0] row;
    logic [15:0] mem [32];
    int n_mismatch, checks, seed, n_wake;
    tsec_top #(.PROG_CYC(PC), .BFS_CYC(BC)) dut (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .scl_clk(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .coil_above_on_thr(above), .coil_below_off_thr(below),
        .coil_damping_ctrl_in(damp_in), .field_gap_detect_out(fgd), .wake_pulse(wake),
        .field_supply(fsup), .pm_auto(pma), .nrst_out(), .nrst_oe(nrst_oe),
        .damp_drive(ddrv), .prog_busy(busy));
    tsec_mst m (.clk(sys_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // wake pulses last one cycle, so count them rather than sample
    always @(posedge sys_clk) if (wake === 1'b1) n_wake++;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // byte i of a sequential read, two bytes per row
    function automatic logic [7:0] exp_rd(logic [4:0] r, logic hi, int i);
        logic [15:0] w;
        w = mem[hi ? r - 5'(i / 2) : r + 5'(i / 2)];
        return (hi ^ i[0]) ? w[15:8] : w[7:0];
    endfunction
    task automatic cmd(input logic [7:0] c, input logic s);
        m.start();
        m.xb(c, 1'b0, q, a);
        chk(a, 1'b1);
        if (s) m.stop();
    endtask
    // write, then poll while busy; the poll must go unanswered
    task automatic wr(input logic [4:0] r, input logic hi, input int n, input logic [15:0] d);
        logic [7:0] v;
        cmd({r, hi, ~hi, 1'b0}, 1'b0);
        for (int i = 0; i < n; i++) begin
            v = (hi ^ i[0]) ? d[15:8] : d[7:0];
            m.xb(v, 1'b0, q, a);
            chk(a, 1'b1);
            if (hi ^ i[0]) mem[r][15:8] = v;
            else mem[r][7:0] = v;
        end
        m.stop();
        chk(busy, 1'b1);
        m.start();
        m.xb({r, 3'h1}, 1'b0, q, a);
        chk(a, 1'b0);
        m.stop();
        for (int t = 0; t < PC + 500 && busy !== 1'b0; t++) @(negedge sys_clk);
        chk(busy, 1'b0);
    endtask
    task automatic rd(input logic [4:0] r, input logic hi, input int n);
        cmd({r, hi, ~hi, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            m.xb(8'hff, i < n - 1, q, a);
            chk(q, exp_rd(r, hi, i));
        end
        m.stop();
        chk(sda_oe, 1'b0);
    endtask
    // rows 31 and 0 force the sequential read to wrap
    initial begin
        seed = 32'h251d;
        {resetn, clk_en, above, below, damp_in} = 5'h0a;
        foreach (mem[i]) mem[i] = 16'h0;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk({pma, sda_oe}, 2'b10);
        for (int k = 0; k < 3; k++) begin
            row = (k == 2) ? 5'($random(seed)) : {5{k[0]}} ^ 5'h1f;
            wr(row, k[0], (k == 2) ? 1 : 2, 16'($random(seed)));
            rd(row, k[0], 3);
            $display("test array %0d done", k);
        end
        {above, below} = 2'b10;
        repeat (10) @(negedge sys_clk);
        chk({fsup, fgd}, 2'b01);
        repeat (BC + 10) @(negedge sys_clk);
        chk({fsup, 8'(n_wake)}, {1'b1, 8'h1});
        cmd(8'he7, 1'b1);
        chk({pma, fsup}, 2'b00);
        cmd(8'hef, 1'b1);
        repeat (BC + 10) @(negedge sys_clk);
        chk({pma, fsup, 8'(n_wake)}, {2'b11, 8'h2});
        {above, below} = 2'b01;
        repeat (12) @(negedge sys_clk);
        chk({fsup, fgd, nrst_oe}, 3'b001);
        $display("test power done");
        // reserved control byte must go unanswered
        m.start();
        m.xb(8'h2e, 1'b0, q, a);
        chk(a, 1'b0);
        m.stop();
        // manchester then bi-phase; bi-phase level toggles once per one bit
        for (int md = 0; md < 2; md++) begin
            cmd(md ? 8'hc7 : 8'hd7, 1'b0);
            e = 1'b0;
            for (int i = 0; i < 9; i++) begin
                b = 1'($random(seed));
                m.bit1(b, a);
                e = md ? e ^ b : ~b;
                chk({ddrv, a}, {e, b});
            end
            m.stop();
        end
        damp_in = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk(ddrv, 1'b1);
        $display("test modulator done");
        test_done();
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        test_done();
    end
endmodule
